/* core/wcr_regs.sv */
// Wetting current level registers with per-channel current selection
`timescale 1ns/10ps
// How it works
// - Register at 1Dh is 24 bits, resets to zero, all fields read and write.
// - Its fields from the top are ch11, ch10, pair 8/9, pair 6/7, ch5, ch4, pair 2/3, pair 0/1.
// - Code 0 is off, 1 is 1 mA, 2 is 2 mA, 3 is 5 mA, 4 is 10 mA, 5 to 7 are 15 mA.
// - A pair field drives both channels of its pair with one code.
// - Register at 1Eh is 24 bits and resets to zero.
// - In 1Eh bit 23 reads zero, bit 22 sink disable, bit 21 source disable, ch23 at 20-18, ch22 at 17-15.
// - With scaling active in continuous mode, a closed input at 10 or 15 mA drops to 2 mA.
// - Bit 22 low lets sink inputs scale down; high stops it.
// - Bit 21 low lets source inputs scale down; high stops it.
// - Low part of 1Eh holds pairs 20/21, 18/19, 16/17, 14/15, 12/13 with the same codes.
// - Channels 0 to 9 pick source at 0 and sink at 1, which selects the governing disable bit.
module wcr_regs
  import wcr_pkg::*;
#(
  parameter int NUM_CH = WCR_NUM_CH
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire wcr_req_t req_in,
  input wire logic continuous_mode_in,
  input wire logic [NUM_CH-1:0] switch_closed_in,
  input wire logic [WCR_NUM_SEL-1:0] current_sink_sel_in,
  output logic [WCR_REG_W-1:0] rdata_out,
  output logic sink_downscale_disable_out,
  output logic source_downscale_disable_out,
  output wcr_level_t [NUM_CH-1:0] level_out
);

  if (NUM_CH != WCR_NUM_CH) begin : g_bad_num_ch
    $error("wcr_regs serves exactly 24 channels");
  end

  //////////////////////////////////////////////////////////////////////
  // Code decode and per-channel field map
  function automatic wcr_level_t wcr_decode(input logic [2:0] code);
    case (code)
      WCR_CODE_OFF: wcr_decode = WCR_I_OFF;
      WCR_CODE_1MA: wcr_decode = WCR_I_1MA;
      WCR_CODE_2MA: wcr_decode = WCR_I_2MA;
      WCR_CODE_5MA: wcr_decode = WCR_I_5MA;
      WCR_CODE_10MA: wcr_decode = WCR_I_10MA;
      default: wcr_decode = WCR_I_15MA;
    endcase
  endfunction

  // Field low bit within its register for each channel
  function automatic int wcr_field_lsb(input int ch);
    case (ch)
      0, 1, 12, 13: wcr_field_lsb = WCR_F0_LSB;
      2, 3, 14, 15: wcr_field_lsb = WCR_F1_LSB;
      4, 16, 17: wcr_field_lsb = WCR_F2_LSB;
      5, 18, 19: wcr_field_lsb = WCR_F3_LSB;
      6, 7, 20, 21: wcr_field_lsb = WCR_F4_LSB;
      8, 9, 22: wcr_field_lsb = WCR_F5_LSB;
      10, 23: wcr_field_lsb = WCR_F6_LSB;
      default: wcr_field_lsb = WCR_F7_LSB;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////
  // State
  wcr_state_t state_reg;
  wcr_state_t state_next;

  always_comb begin
    state_next = state_reg;
    if (req_in.wr && req_in.addr == WCR_OFS_LOW) begin
      state_next.low = req_in.wdata;
    end
    if (req_in.wr && req_in.addr == WCR_OFS_HIGH) begin
      state_next.high = req_in.wdata & WCR_HIGH_WMASK;
    end
    case (req_in.addr)
      WCR_OFS_LOW: state_next.rdata = state_reg.low;
      WCR_OFS_HIGH: state_next.rdata = state_reg.high & WCR_HIGH_WMASK;
      default: state_next.rdata = '0;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state_reg.low <= WCR_LOW_RST;
      state_reg.high <= WCR_HIGH_RST;
      state_reg.rdata <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdata_out = state_reg.rdata;
  assign sink_downscale_disable_out = state_reg.high[WCR_SINK_DIS_BIT];
  assign source_downscale_disable_out = state_reg.high[WCR_SRC_DIS_BIT];

  //////////////////////////////////////////////////////////////////////
  // Per-channel level with closure downscaling
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      localparam int LSB = wcr_field_lsb(g);
      logic [2:0] code;
      logic is_sink;
      logic scale_dis;
      wcr_level_t base;
      if (g < 12) begin : g_low
        assign code = state_reg.low[LSB +: 3];
      end else begin : g_high
        assign code = state_reg.high[LSB +: 3];
      end
      if (g < WCR_NUM_SEL) begin : g_sel
        assign is_sink = current_sink_sel_in[g];
      end else begin : g_src
        assign is_sink = 1'h0;
      end
      assign scale_dis = is_sink ? state_reg.high[WCR_SINK_DIS_BIT] : state_reg.high[WCR_SRC_DIS_BIT];
      assign base = wcr_decode(code);
      always_comb begin
        level_out[g] = base;
        if (continuous_mode_in && !scale_dis && switch_closed_in[g] &&
            (base == WCR_I_10MA || base == WCR_I_15MA)) begin
          level_out[g] = WCR_I_2MA;
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////
  // Checks
  property p_rsvd_zero;
    @(posedge clk_in) disable iff (!nrst_in)
      state_reg.high[WCR_RSVD_BIT] == 1'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set");

  property p_low_write;
    @(posedge clk_in) disable iff (!nrst_in)
      req_in.wr && req_in.addr == WCR_OFS_LOW |=> state_reg.low == $past(req_in.wdata);
  endproperty
  a_low_write: assert property (p_low_write) else $error("low register write lost");

  property p_low_readback;
    @(posedge clk_in) disable iff (!nrst_in)
      !req_in.wr ##0 req_in.addr == WCR_OFS_LOW |=> rdata_out == $past(state_reg.low);
  endproperty
  a_low_readback: assert property (p_low_readback) else $error("low readback wrong");

  property p_high_read_rsvd;
    @(posedge clk_in) disable iff (!nrst_in)
      req_in.addr == WCR_OFS_HIGH |=> rdata_out[WCR_RSVD_BIT] == 1'h0;
  endproperty
  a_high_read_rsvd: assert property (p_high_read_rsvd) else $error("reserved bit read as one");

  property p_reset_clears;
    @(posedge clk_in) !nrst_in |=> state_reg.low == '0 && state_reg.high == '0;
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("reset did not clear");

  property p_pair_equal;
    @(posedge clk_in) disable iff (!nrst_in)
      !switch_closed_in[0] && !switch_closed_in[1] && current_sink_sel_in[0] == current_sink_sel_in[1]
      |-> level_out[0] == level_out[1];
  endproperty
  a_pair_equal: assert property (p_pair_equal) else $error("pair levels differ");

  property p_code_high;
    @(posedge clk_in) disable iff (!nrst_in)
      state_reg.low[WCR_F7_LSB +: 3] >= 3'h5 && !switch_closed_in[11] |-> level_out[11] == WCR_I_15MA;
  endproperty
  a_code_high: assert property (p_code_high) else $error("code above four not 15 mA");

  property p_downscale;
    @(posedge clk_in) disable iff (!nrst_in)
      continuous_mode_in && switch_closed_in[23] && !state_reg.high[WCR_SRC_DIS_BIT] &&
      state_reg.high[WCR_F6_LSB +: 3] >= 3'h4 |-> level_out[23] == WCR_I_2MA;
  endproperty
  a_downscale: assert property (p_downscale) else $error("no downscale on closure");

  property p_sink_dis;
    @(posedge clk_in) disable iff (!nrst_in)
      current_sink_sel_in[5] && state_reg.high[WCR_SINK_DIS_BIT] |-> level_out[5] == wcr_decode(state_reg.low[WCR_F3_LSB +: 3]);
  endproperty
  a_sink_dis: assert property (p_sink_dis) else $error("sink disable ignored");

  property p_src_dis;
    @(posedge clk_in) disable iff (!nrst_in)
      !current_sink_sel_in[4] && state_reg.high[WCR_SRC_DIS_BIT] |-> level_out[4] == wcr_decode(state_reg.low[WCR_F2_LSB +: 3]);
  endproperty
  a_src_dis: assert property (p_src_dis) else $error("source disable ignored");

  property p_high_write;
    @(posedge clk_in) disable iff (!nrst_in)
      req_in.wr && req_in.addr == WCR_OFS_HIGH |=> state_reg.high == ($past(req_in.wdata) & WCR_HIGH_WMASK);
  endproperty
  a_high_write: assert property (p_high_write) else $error("high register write lost");

  property p_high_readback;
    @(posedge clk_in) disable iff (!nrst_in)
      !req_in.wr && req_in.addr == WCR_OFS_HIGH |=> rdata_out == $past(state_reg.high);
  endproperty
  a_high_readback: assert property (p_high_readback) else $error("high readback wrong");

  property p_low_hold;
    @(posedge clk_in) disable iff (!nrst_in)
      !(req_in.wr && req_in.addr == WCR_OFS_LOW) |=> $stable(state_reg.low);
  endproperty
  a_low_hold: assert property (p_low_hold) else $error("low register changed without write");

  property p_high_hold;
    @(posedge clk_in) disable iff (!nrst_in)
      !(req_in.wr && req_in.addr == WCR_OFS_HIGH) |=> $stable(state_reg.high);
  endproperty
  a_high_hold: assert property (p_high_hold) else $error("high register changed without write");

  property p_sink_bit_write;
    @(posedge clk_in) disable iff (!nrst_in)
      req_in.wr && req_in.addr == WCR_OFS_HIGH |=>
      sink_downscale_disable_out == $past(req_in.wdata[WCR_SINK_DIS_BIT]);
  endproperty
  a_sink_bit_write: assert property (p_sink_bit_write) else $error("sink disable bit not written");

  property p_src_bit_write;
    @(posedge clk_in) disable iff (!nrst_in)
      req_in.wr && req_in.addr == WCR_OFS_HIGH |=>
      source_downscale_disable_out == $past(req_in.wdata[WCR_SRC_DIS_BIT]);
  endproperty
  a_src_bit_write: assert property (p_src_bit_write) else $error("source disable bit not written");

  property p_code_off;
    @(posedge clk_in) disable iff (!nrst_in)
      state_reg.low[WCR_F0_LSB +: 3] == WCR_CODE_OFF |-> level_out[0] == WCR_I_OFF && level_out[1] == WCR_I_OFF;
  endproperty
  a_code_off: assert property (p_code_off) else $error("code zero not off");

  property p_code_one;
    @(posedge clk_in) disable iff (!nrst_in)
      state_reg.low[WCR_F6_LSB +: 3] == WCR_CODE_1MA |-> level_out[10] == WCR_I_1MA;
  endproperty
  a_code_one: assert property (p_code_one) else $error("code one not 1 mA");

  property p_code_two;
    @(posedge clk_in) disable iff (!nrst_in)
      state_reg.low[WCR_F7_LSB +: 3] == WCR_CODE_2MA |-> level_out[11] == WCR_I_2MA;
  endproperty
  a_code_two: assert property (p_code_two) else $error("code two not 2 mA");

  property p_pair_twelve;
    @(posedge clk_in) disable iff (!nrst_in)
      switch_closed_in[12] == switch_closed_in[13] |-> level_out[12] == level_out[13];
  endproperty
  a_pair_twelve: assert property (p_pair_twelve) else $error("pair twelve levels differ");

  property p_pair_six_seven;
    @(posedge clk_in) disable iff (!nrst_in)
      !switch_closed_in[6] && !switch_closed_in[7] |-> level_out[6] == level_out[7];
  endproperty
  a_pair_six_seven: assert property (p_pair_six_seven) else $error("pair six levels differ");

  property p_ch22_code;
    @(posedge clk_in) disable iff (!nrst_in)
      state_reg.high[WCR_F5_LSB +: 3] == WCR_CODE_5MA |-> level_out[22] == WCR_I_5MA;
  endproperty
  a_ch22_code: assert property (p_ch22_code) else $error("channel 22 field wrong");

  property p_no_scale_polling;
    @(posedge clk_in) disable iff (!nrst_in)
      !continuous_mode_in && state_reg.high[WCR_F6_LSB +: 3] >= WCR_CODE_10MA |->
      level_out[23] inside {WCR_I_10MA, WCR_I_15MA};
  endproperty
  a_no_scale_polling: assert property (p_no_scale_polling) else $error("downscale outside continuous mode");

  property p_no_scale_open;
    @(posedge clk_in) disable iff (!nrst_in)
      !switch_closed_in[11] && state_reg.low[WCR_F7_LSB +: 3] == WCR_CODE_10MA |-> level_out[11] == WCR_I_10MA;
  endproperty
  a_no_scale_open: assert property (p_no_scale_open) else $error("downscale on open switch");

  property p_low_code_kept;
    @(posedge clk_in) disable iff (!nrst_in)
      switch_closed_in[10] && state_reg.low[WCR_F6_LSB +: 3] == WCR_CODE_5MA |-> level_out[10] == WCR_I_5MA;
  endproperty
  a_low_code_kept: assert property (p_low_code_kept) else $error("5 mA level scaled");

  property p_sink_scale;
    @(posedge clk_in) disable iff (!nrst_in)
      continuous_mode_in && switch_closed_in[5] && current_sink_sel_in[5] &&
      !state_reg.high[WCR_SINK_DIS_BIT] && state_reg.low[WCR_F3_LSB +: 3] >= WCR_CODE_10MA
      |-> level_out[5] == WCR_I_2MA;
  endproperty
  a_sink_scale: assert property (p_sink_scale) else $error("sink input not scaled");

  property p_src_scale;
    @(posedge clk_in) disable iff (!nrst_in)
      continuous_mode_in && switch_closed_in[4] && !current_sink_sel_in[4] &&
      !state_reg.high[WCR_SRC_DIS_BIT] && state_reg.low[WCR_F2_LSB +: 3] >= WCR_CODE_10MA
      |-> level_out[4] == WCR_I_2MA;
  endproperty
  a_src_scale: assert property (p_src_scale) else $error("source input not scaled");

  property p_sel_governs;
    @(posedge clk_in) disable iff (!nrst_in)
      continuous_mode_in && switch_closed_in[3] && current_sink_sel_in[3] && state_reg.high[WCR_SRC_DIS_BIT] &&
      !state_reg.high[WCR_SINK_DIS_BIT] && state_reg.low[WCR_F1_LSB +: 3] >= WCR_CODE_10MA
      |-> level_out[3] == WCR_I_2MA;
  endproperty
  a_sel_governs: assert property (p_sel_governs) else $error("wrong disable bit governs sink");

  property p_high_src_only;
    @(posedge clk_in) disable iff (!nrst_in)
      continuous_mode_in && switch_closed_in[12] && state_reg.high[WCR_SINK_DIS_BIT] &&
      !state_reg.high[WCR_SRC_DIS_BIT] && state_reg.high[WCR_F0_LSB +: 3] >= WCR_CODE_10MA
      |-> level_out[12] == WCR_I_2MA;
  endproperty
  a_high_src_only: assert property (p_high_src_only) else $error("upper channel not source side");

  property p_reset_outputs;
    @(posedge clk_in) !nrst_in |=> !sink_downscale_disable_out && !source_downscale_disable_out;
  endproperty
  a_reset_outputs: assert property (p_reset_outputs) else $error("disable bits set after reset");

  property p_reset_level;
    @(posedge clk_in) !nrst_in |=> level_out[0] == WCR_I_OFF && level_out[23] == WCR_I_OFF && rdata_out == '0;
  endproperty
  a_reset_level: assert property (p_reset_level) else $error("levels not off after reset");

endmodule

/* shared/wcr_pkg.sv */
// Package for the wetting current level register pair
package wcr_pkg;
  localparam logic [5:0] WCR_OFS_LOW = 6'h1d;
  localparam logic [5:0] WCR_OFS_HIGH = 6'h1e;
  localparam int WCR_REG_W = 24;
  localparam int WCR_CODE_W = 3;
  localparam int WCR_NUM_CH = 24;
  localparam int WCR_NUM_SEL = 10;
  localparam logic [23:0] WCR_LOW_RST = 24'h000000;
  localparam logic [23:0] WCR_HIGH_RST = 24'h000000;
  localparam logic [23:0] WCR_HIGH_WMASK = 24'h7fffff;
  localparam int WCR_RSVD_BIT = 23;
  localparam int WCR_SINK_DIS_BIT = 22;
  localparam int WCR_SRC_DIS_BIT = 21;
  // Field low bits; F0 to F6 serve both registers, F7 serves the low register only
  localparam int WCR_F7_LSB = 21;
  localparam int WCR_F6_LSB = 18;
  localparam int WCR_F5_LSB = 15;
  localparam int WCR_F4_LSB = 12;
  localparam int WCR_F3_LSB = 9;
  localparam int WCR_F2_LSB = 6;
  localparam int WCR_F1_LSB = 3;
  localparam int WCR_F0_LSB = 0;
  // Level codes
  localparam logic [2:0] WCR_CODE_OFF = 3'h0;
  localparam logic [2:0] WCR_CODE_1MA = 3'h1;
  localparam logic [2:0] WCR_CODE_2MA = 3'h2;
  localparam logic [2:0] WCR_CODE_5MA = 3'h3;
  localparam logic [2:0] WCR_CODE_10MA = 3'h4;

  typedef enum logic [2:0] {
    WCR_I_OFF = 3'h0,
    WCR_I_1MA = 3'h1,
    WCR_I_2MA = 3'h2,
    WCR_I_5MA = 3'h3,
    WCR_I_10MA = 3'h4,
    WCR_I_15MA = 3'h5
  } wcr_level_t;

  typedef struct packed {
    logic wr;
    logic [5:0] addr;
    logic [23:0] wdata;
  } wcr_req_t;

  typedef struct packed {
    logic [23:0] low;
    logic [23:0] high;
    logic [23:0] rdata;
  } wcr_state_t;
endpackage

/* sim/wcr_host.sv */
// Host-side register access model for the wetting level registers
`timescale 1ns/10ps
module wcr_host
  import wcr_pkg::*;
(
  input wire logic clk_in,
  input wire logic [23:0] rdata_in,
  output wcr_req_t req_out
);
  initial req_out = '0;
  ////////////////////////////////////////////////////////////////////////
  // Write strobe held for one edge, data scrambled once released
  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    @(posedge clk_in);
    #1 req_out = '{wr: 1'b1, addr: a, wdata: d};
    @(posedge clk_in);
    #1 req_out.wr = 1'b0;
    req_out.wdata = ~d;
  endtask
  // Address sampled at one edge, data taken after it
  task automatic rd(input logic [5:0] a, output logic [23:0] d);
    @(posedge clk_in);
    #1 req_out.addr = a;
    @(posedge clk_in);
    #1 d = rdata_in;
  endtask
endmodule

/* sim/wetting_current_config_regs_test.sv */
// Self-checking bench for the wetting level registers
`timescale 1ns/10ps
module wetting_current_config_regs_test
  import wcr_pkg::*;
;
  logic clk_in = 1'b0;
  logic nrst = 1'b0;
  logic cont = 1'b0;
  logic [23:0] closed = '0;
  logic [9:0] sel = '0;
  logic [23:0] rdata;
  logic sink_dis;
  logic src_dis;
  wcr_level_t [23:0] lvl;
  wcr_req_t req;
  logic [23:0] lo_m = '0;
  logic [23:0] hi_m = '0;
  logic [23:0] d;
  logic [23:0] w;
  logic [5:0] a;
  int err_count = 0;
  int checked = 0;
  int lsb_t[24] = '{0, 0, 3, 3, 6, 9, 12, 12, 15, 15, 18, 21, 0, 0, 3, 3, 6, 6, 9, 9, 12, 12, 15, 18};
  always #10 clk_in = ~clk_in;
  wcr_host host (.clk_in(clk_in), .rdata_in(rdata), .req_out(req));
  wcr_regs #(.NUM_CH(24)) DUT (.clk_in(clk_in), .nrst_in(nrst), .req_in(req), .continuous_mode_in(cont),
    .switch_closed_in(closed), .current_sink_sel_in(sel), .rdata_out(rdata),
    .sink_downscale_disable_out(sink_dis), .source_downscale_disable_out(src_dis), .level_out(lvl));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Expected current level of one channel
  function automatic logic [2:0] exp_level(input int c);
    int code;
    logic dis;
    code = int'(((c < 12 ? lo_m : hi_m) >> lsb_t[c]) & 24'h7);
    if (code > 5) code = 5;
    dis = (c < 10 && sel[c]) ? hi_m[22] : hi_m[21];
    if (cont && closed[c] && code >= 4 && !dis) code = 2;
    return 3'(code);
  endfunction
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'hdfafe45c));
    repeat (8) @(posedge clk_in);
    #1 nrst = 1'b1;
    host.rd(6'h1d, d);
    check(d, 24'h000000);
    host.rd(6'h1e, d);
    check(d, 24'h000000);
    for (int i = 0; i < 60; i++) begin
      a = (i % 3 == 2) ? 6'h1f : 6'(6'h1d + i % 3);
      w = (i == 1) ? 24'hffffff : 24'($urandom);
      host.wr(a, w);
      if (a == 6'h1d) lo_m = w;
      else if (a == 6'h1e) hi_m = w & 24'h7fffff;
      host.rd(a, d);
      check(d, a == 6'h1d ? lo_m : (a == 6'h1e ? hi_m : 24'h000000));
      @(posedge clk_in);
      #1 cont = 1'($urandom % 4 != 0);
      closed = 24'($urandom);
      sel = 10'($urandom);
      #1 check({22'h0, sink_dis, src_dis}, {22'h0, hi_m[22], hi_m[21]});
      for (int c = 0; c < 24; c++) begin
        check(24'(lvl[c]), 24'(exp_level(c)));
      end
    end
    tally_and_finish();
  end
endmodule
